// *** verilog/dbs_pkg.sv ***
// dbs_pkg: shared constants, states and layouts of the dual byte register with boundary scan
`default_nettype none
package dbs_pkg;

    // ------------------------------------------------------------------
    // bank geometry
    // ------------------------------------------------------------------
    localparam int BANK_W = 9;

    // ------------------------------------------------------------------
    // test access port states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } dbs_tap_e;

    // ------------------------------------------------------------------
    // data register selection
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {DBS_TDR_BYPASS, DBS_TDR_IDENT, DBS_TDR_BOUNDARY} dbs_tdr_e;

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam int IR_W = 8;
    localparam logic [7:0] IR_EXTEST = 8'h00;
    localparam logic [7:0] IR_SAMPLE = 8'h81;
    localparam logic [7:0] IR_CLAMP = 8'h82;
    localparam logic [7:0] IR_HIGHZ = 8'h03;
    localparam logic [7:0] IR_SAMPLE_IN = 8'h41;
    localparam logic [7:0] IR_SAMPLE_OUT = 8'h42;
    localparam logic [7:0] IR_OUTPUT_ONLY_EXTERNAL_TEST = 8'h22;
    localparam logic [7:0] IR_IDENT = 8'hAA;
    localparam logic [7:0] IR_BYPASS = 8'hFF;
    localparam logic [7:0] IR_CAPTURE = 8'h81;

    // ------------------------------------------------------------------
    // identification register layout
    // ------------------------------------------------------------------
    localparam int ID_W = 32;
    localparam int ID_VER_W = 4;
    localparam int ID_ENT_W = 6;
    localparam int ID_PART_W = 10;
    localparam int ID_MFR_W = 11;
    localparam logic ID_LSB = 1'b1;

    // ------------------------------------------------------------------
    // boundary chain layout
    // ------------------------------------------------------------------
    localparam int BSR_W = 42;
    localparam int BSR_A_PIN = 41;
    localparam int BSR_A_CLK = 40;
    localparam int BSR_A_INT = 39;
    localparam int BSR_B_PIN = 38;
    localparam int BSR_B_CLK = 37;
    localparam int BSR_B_INT = 36;
    localparam int BSR_A_IN0 = 35;
    localparam int BSR_B_IN0 = 26;
    localparam int BSR_A_OUT0 = 17;
    localparam int BSR_B_OUT0 = 8;
    localparam logic [41:0] BSR_IN_MASK = 42'h36FFFFC0000;
    localparam int CELLS_W = 20;

endpackage : dbs_pkg
`default_nettype wire

// *** verilog/dbs_top.sv ***
// dbs_top: two 9-bit register banks with tri-state outputs behind a boundary-scan test port
//
// Summary of operation
// - two banks of nine bits, each own clock
// - clock and enable act on own bank only
// - enable pin low shows data, high floats
// - enable changes never touch stored bits
// - outputs float until enable goes high then low
// - standard test port with tdi tdo tms tck
// - observe cells on inputs, control cells on outputs
// - internal active-high enable per bank gates outputs
// - bypass is one stage capturing zero
// - identity word: version, entity, part, maker, one
// - eight-bit instruction captures sample code
// - capture, exit, update yields sample instruction
// - decode extest, sample, clamp, high-z codes
// - decode input sample, output sample, output test
// - identity code, bypass code, unknown selects bypass
// - top six chain bits are control signals
// - chain bits observe bank a then b inputs
// - low chain bits control bank outputs
`timescale 1ns/100ps
`default_nettype none
module dbs_top #(
    parameter logic [3:0] ID_VERSION = 4'h1,   // arbitrary value
    parameter logic [5:0] ID_ENTITY = 6'h05,   // arbitrary value
    parameter logic [9:0] ID_PART = 10'h0A5,   // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055  // arbitrary value
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_en,
    input wire logic [8:0] bank_a_data_in,
    input wire logic [8:0] bank_b_data_in,
    input wire logic bank_a_clock,
    input wire logic bank_b_clock,
    input wire logic bank_a_enable_pin_n,
    input wire logic bank_b_enable_pin_n,
    output logic [8:0] bank_a_data_out,
    output logic bank_a_out_en,
    output logic [8:0] bank_b_data_out,
    output logic bank_b_out_en
);

    // ------------------------------------------------------------------
    // system clock domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [8:0] a_in_m;
        logic [8:0] a_in_s;
        logic [8:0] b_in_m;
        logic [8:0] b_in_s;
        logic [1:0] clk_m;
        logic [1:0] clk_s;
        logic [1:0] clk_p;
        logic [1:0] en_m;
        logic [1:0] en_s;
        logic [1:0] seen_hi;
        logic [8:0] a_store;
        logic [8:0] b_store;
        logic tg_m;
        logic tg_s;
        logic tg_p;
        logic ext;
        logic hiz;
        logic [19:0] cells;
        logic [41:0] obs;
        logic [8:0] a_out;
        logic [8:0] b_out;
        logic a_oe;
        logic b_oe;
    } dbs_sys_s;

    // ------------------------------------------------------------------
    // test clock domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        dbs_pkg::dbs_tap_e state;
        logic [7:0] ir_sh;
        logic [7:0] ir_act;
        logic byp;
        logic [31:0] id_sh;
        logic [41:0] bsr_sh;
        logic [41:0] bsr_up;
        logic [41:0] obs_m;
        logic [41:0] obs_s;
        logic ext;
        logic hiz;
        logic tgl;
    } dbs_tap_s;

    dbs_sys_s s_q;
    dbs_sys_s s_d;
    dbs_tap_s t_q;
    dbs_tap_s t_d;
    logic tdo_q;
    logic tdo_en_q;
    logic tdo_d;
    logic tdo_en_d;

    localparam logic [31:0] ID_WORD = {ID_VERSION, ID_ENTITY, ID_PART, ID_MAKER,
        dbs_pkg::ID_LSB};

    // ------------------------------------------------------------------
    // instruction decode helpers
    // ------------------------------------------------------------------
    function automatic dbs_pkg::dbs_tdr_e tdr_sel(input logic [7:0] ir);
        dbs_pkg::dbs_tdr_e r;
        r = dbs_pkg::DBS_TDR_BYPASS;
        unique case (ir)
            dbs_pkg::IR_EXTEST, dbs_pkg::IR_SAMPLE, dbs_pkg::IR_SAMPLE_IN,
            dbs_pkg::IR_SAMPLE_OUT, dbs_pkg::IR_OUTPUT_ONLY_EXTERNAL_TEST: begin
                r = dbs_pkg::DBS_TDR_BOUNDARY;
            end
            dbs_pkg::IR_IDENT: r = dbs_pkg::DBS_TDR_IDENT;
            default: r = dbs_pkg::DBS_TDR_BYPASS;
        endcase
        return r;
    endfunction : tdr_sel

    function automatic logic [41:0] cap_mask(input logic [7:0] ir);
        logic [41:0] m;
        m = '1;
        if (ir == dbs_pkg::IR_SAMPLE_IN) begin
            m = dbs_pkg::BSR_IN_MASK;
        end else if (ir == dbs_pkg::IR_SAMPLE_OUT) begin
            m = ~dbs_pkg::BSR_IN_MASK;
        end
        return m;
    endfunction : cap_mask

    // ------------------------------------------------------------------
    // system domain next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [1:0] int_en;
        logic [1:0] rise;
        int_en = '0;
        rise = '0;
        s_d = s_q;
        s_d.a_in_m = bank_a_data_in;
        s_d.a_in_s = s_q.a_in_m;
        s_d.b_in_m = bank_b_data_in;
        s_d.b_in_s = s_q.b_in_m;
        s_d.clk_m = {bank_b_clock, bank_a_clock};
        s_d.clk_s = s_q.clk_m;
        s_d.clk_p = s_q.clk_s;
        s_d.en_m = {bank_b_enable_pin_n, bank_a_enable_pin_n};
        s_d.en_s = s_q.en_m;
        s_d.seen_hi = s_q.seen_hi | s_q.en_s;
        int_en = s_q.seen_hi & ~s_q.en_s;
        rise = s_q.clk_s & ~s_q.clk_p;
        if (rise[0]) begin
            s_d.a_store = s_q.a_in_s;
        end
        if (rise[1]) begin
            s_d.b_store = s_q.b_in_s;
        end
        // control word from the test port, taken once its toggle settles
        s_d.tg_m = t_q.tgl;
        s_d.tg_s = s_q.tg_m;
        s_d.tg_p = s_q.tg_s;
        if (s_q.tg_s != s_q.tg_p) begin
            s_d.ext = t_q.ext;
            s_d.hiz = t_q.hiz;
            s_d.cells = {t_q.bsr_up[dbs_pkg::BSR_A_INT], t_q.bsr_up[dbs_pkg::BSR_B_INT],
                t_q.bsr_up[17:0]};
        end
        // observed pin and core values
        s_d.obs[dbs_pkg::BSR_A_PIN] = s_q.en_s[0];
        s_d.obs[dbs_pkg::BSR_A_CLK] = s_q.clk_s[0];
        s_d.obs[dbs_pkg::BSR_A_INT] = int_en[0];
        s_d.obs[dbs_pkg::BSR_B_PIN] = s_q.en_s[1];
        s_d.obs[dbs_pkg::BSR_B_CLK] = s_q.clk_s[1];
        s_d.obs[dbs_pkg::BSR_B_INT] = int_en[1];
        for (int i = 0; i < dbs_pkg::BANK_W; i++) begin
            s_d.obs[dbs_pkg::BSR_A_IN0 - i] = s_q.a_in_s[i];
            s_d.obs[dbs_pkg::BSR_B_IN0 - i] = s_q.b_in_s[i];
            s_d.obs[dbs_pkg::BSR_A_OUT0 - i] = s_q.a_store[i];
            s_d.obs[dbs_pkg::BSR_B_OUT0 - i] = s_q.b_store[i];
        end
        // output drive
        if (s_q.hiz) begin
            s_d.a_out = s_q.a_store;
            s_d.b_out = s_q.b_store;
            s_d.a_oe = 1'b0;
            s_d.b_oe = 1'b0;
        end else if (s_q.ext) begin
            for (int i = 0; i < dbs_pkg::BANK_W; i++) begin
                s_d.a_out[i] = s_q.cells[dbs_pkg::BSR_A_OUT0 - i];
                s_d.b_out[i] = s_q.cells[dbs_pkg::BSR_B_OUT0 - i];
            end
            s_d.a_oe = s_q.cells[19];
            s_d.b_oe = s_q.cells[18];
        end else begin
            s_d.a_out = s_q.a_store;
            s_d.b_out = s_q.b_store;
            s_d.a_oe = int_en[0];
            s_d.b_oe = int_en[1];
        end
    end

    // ------------------------------------------------------------------
    // system domain registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // test port next state
    // ------------------------------------------------------------------
    always_comb begin
        dbs_pkg::dbs_tdr_e sel;
        logic [41:0] msk;
        sel = tdr_sel(t_q.ir_act);
        msk = cap_mask(t_q.ir_act);
        t_d = t_q;
        t_d.obs_m = s_q.obs;
        t_d.obs_s = t_q.obs_m;
        unique case (t_q.state)
            dbs_pkg::TAP_RESET: t_d.state = tms ? dbs_pkg::TAP_RESET : dbs_pkg::TAP_IDLE;
            dbs_pkg::TAP_IDLE: t_d.state = tms ? dbs_pkg::TAP_SEL_DR : dbs_pkg::TAP_IDLE;
            dbs_pkg::TAP_SEL_DR: t_d.state = tms ? dbs_pkg::TAP_SEL_IR : dbs_pkg::TAP_CAP_DR;
            dbs_pkg::TAP_CAP_DR: t_d.state = tms ? dbs_pkg::TAP_EX1_DR : dbs_pkg::TAP_SH_DR;
            dbs_pkg::TAP_SH_DR: t_d.state = tms ? dbs_pkg::TAP_EX1_DR : dbs_pkg::TAP_SH_DR;
            dbs_pkg::TAP_EX1_DR: t_d.state = tms ? dbs_pkg::TAP_UPD_DR : dbs_pkg::TAP_PAU_DR;
            dbs_pkg::TAP_PAU_DR: t_d.state = tms ? dbs_pkg::TAP_EX2_DR : dbs_pkg::TAP_PAU_DR;
            dbs_pkg::TAP_EX2_DR: t_d.state = tms ? dbs_pkg::TAP_UPD_DR : dbs_pkg::TAP_SH_DR;
            dbs_pkg::TAP_UPD_DR: t_d.state = tms ? dbs_pkg::TAP_SEL_DR : dbs_pkg::TAP_IDLE;
            dbs_pkg::TAP_SEL_IR: t_d.state = tms ? dbs_pkg::TAP_RESET : dbs_pkg::TAP_CAP_IR;
            dbs_pkg::TAP_CAP_IR: t_d.state = tms ? dbs_pkg::TAP_EX1_IR : dbs_pkg::TAP_SH_IR;
            dbs_pkg::TAP_SH_IR: t_d.state = tms ? dbs_pkg::TAP_EX1_IR : dbs_pkg::TAP_SH_IR;
            dbs_pkg::TAP_EX1_IR: t_d.state = tms ? dbs_pkg::TAP_UPD_IR : dbs_pkg::TAP_PAU_IR;
            dbs_pkg::TAP_PAU_IR: t_d.state = tms ? dbs_pkg::TAP_EX2_IR : dbs_pkg::TAP_PAU_IR;
            dbs_pkg::TAP_EX2_IR: t_d.state = tms ? dbs_pkg::TAP_UPD_IR : dbs_pkg::TAP_SH_IR;
            dbs_pkg::TAP_UPD_IR: t_d.state = tms ? dbs_pkg::TAP_SEL_DR : dbs_pkg::TAP_IDLE;
        endcase
        unique case (t_q.state)
            dbs_pkg::TAP_RESET: begin
                t_d.ir_act = dbs_pkg::IR_IDENT;
            end
            dbs_pkg::TAP_CAP_IR: begin
                t_d.ir_sh = dbs_pkg::IR_CAPTURE;
            end
            dbs_pkg::TAP_SH_IR: begin
                t_d.ir_sh = {tdi, t_q.ir_sh[7:1]};
            end
            dbs_pkg::TAP_UPD_IR: begin
                t_d.ir_act = t_q.ir_sh;
            end
            dbs_pkg::TAP_CAP_DR: begin
                t_d.byp = 1'b0;
                t_d.id_sh = ID_WORD;
                if (sel == dbs_pkg::DBS_TDR_BOUNDARY) begin
                    t_d.bsr_sh = (t_q.obs_s & msk) | (t_q.bsr_sh & ~msk);
                end
            end
            dbs_pkg::TAP_SH_DR: begin
                unique case (sel)
                    dbs_pkg::DBS_TDR_BOUNDARY: t_d.bsr_sh = {tdi, t_q.bsr_sh[41:1]};
                    dbs_pkg::DBS_TDR_IDENT: t_d.id_sh = {tdi, t_q.id_sh[31:1]};
                    dbs_pkg::DBS_TDR_BYPASS: t_d.byp = tdi;
                endcase
            end
            dbs_pkg::TAP_UPD_DR: begin
                if (sel == dbs_pkg::DBS_TDR_BOUNDARY) begin
                    t_d.bsr_up = t_q.bsr_sh;
                end
            end
            default: begin
            end
        endcase
        t_d.ext = (t_d.ir_act == dbs_pkg::IR_EXTEST) || (t_d.ir_act == dbs_pkg::IR_CLAMP)
            || (t_d.ir_act == dbs_pkg::IR_OUTPUT_ONLY_EXTERNAL_TEST);
        t_d.hiz = (t_d.ir_act == dbs_pkg::IR_HIGHZ);
        if ({t_d.ext, t_d.hiz, t_d.bsr_up} != {t_q.ext, t_q.hiz, t_q.bsr_up}) begin
            t_d.tgl = ~t_q.tgl;
        end
        // serial output, driven on the falling edge
        tdo_en_d = (t_q.state == dbs_pkg::TAP_SH_IR)
            || (t_q.state == dbs_pkg::TAP_SH_DR);
        if (t_q.state == dbs_pkg::TAP_SH_IR) begin
            tdo_d = t_q.ir_sh[0];
        end else if (sel == dbs_pkg::DBS_TDR_BOUNDARY) begin
            tdo_d = t_q.bsr_sh[0];
        end else if (sel == dbs_pkg::DBS_TDR_IDENT) begin
            tdo_d = t_q.id_sh[0];
        end else begin
            tdo_d = t_q.byp;
        end
    end

    // ------------------------------------------------------------------
    // test port registers
    // ------------------------------------------------------------------
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            t_q <= '0;
            t_q.state <= dbs_pkg::TAP_RESET;
            t_q.ir_act <= dbs_pkg::IR_IDENT;
        end else begin
            t_q <= t_d;
        end
    end

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
            tdo_en_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdo_en_q <= tdo_en_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign tdo = tdo_q;
    assign tdo_en = tdo_en_q;
    assign bank_a_data_out = s_q.a_out;
    assign bank_a_out_en = s_q.a_oe;
    assign bank_b_data_out = s_q.b_out;
    assign bank_b_out_en = s_q.b_oe;

endmodule : dbs_top
`default_nettype wire

// *** verif/dbs_top_chk.sv ***
// dbs_top_chk: port-level assertions for dbs_top
`timescale 1ns/100ps
`default_nettype none
module dbs_top_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_en,
    input wire logic bank_a_clock,
    input wire logic bank_a_enable_pin_n,
    input wire logic bank_b_enable_pin_n,
    input wire logic [8:0] bank_a_data_out,
    input wire logic bank_a_out_en,
    input wire logic bank_b_out_en
);
    // ------------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------------
    logic tap_q;
    logic seen_a_q;
    logic seen_b_q;
    logic [3:0] age_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tap_q <= 1'h0;
            seen_a_q <= 1'h0;
            seen_b_q <= 1'h0;
            age_q <= 4'hF;
        end else begin
            tap_q <= tap_q | tck;
            seen_a_q <= seen_a_q | bank_a_enable_pin_n;
            seen_b_q <= seen_b_q | bank_b_enable_pin_n;
            age_q <= bank_a_clock ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_tdo_en_fall: assert property ($changed(tdo_en) |-> !tck)
        else $error("tdo enable moved off a falling test clock");
    chk_tdo_data_fall: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved off a falling test clock");
    chk_a_power_arm: assert property (!tap_q && !seen_a_q |-> !bank_a_out_en)
        else $error("bank a driven before enable went high");
    chk_b_power_arm: assert property (!tap_q && !seen_b_q |-> !bank_b_out_en)
        else $error("bank b driven before enable went high");
    chk_a_on_cause: assert property (!tap_q && $rose(bank_a_out_en)
        |-> !$past(bank_a_enable_pin_n, 2))
        else $error("bank a turned on without its pin low");
    chk_a_off_pin: assert property (!tap_q && bank_a_enable_pin_n [*5]
        |-> !bank_a_out_en)
        else $error("bank a still driven with pin high");
    chk_b_off_pin: assert property (!tap_q && bank_b_enable_pin_n [*5]
        |-> !bank_b_out_en)
        else $error("bank b still driven with its pin high");
    chk_a_store_clock: assert property (!tap_q && bank_a_out_en
        && $past(bank_a_out_en) && $changed(bank_a_data_out) |-> age_q < 4'h8)
        else $error("bank a data moved without a clock edge");
    cov_a_on: cover property ($rose(bank_a_out_en));
    cov_b_on: cover property ($rose(bank_b_out_en));
    cov_shift: cover property ($rose(tdo_en));
endmodule : dbs_top_chk
bind dbs_top dbs_top_chk chk_u (.clock(clock), .rst_n(rst_n), .tck(tck), .tdo(tdo),
    .tdo_en(tdo_en), .bank_a_clock(bank_a_clock),
    .bank_a_enable_pin_n(bank_a_enable_pin_n), .bank_b_enable_pin_n(bank_b_enable_pin_n),
    .bank_a_data_out(bank_a_data_out), .bank_a_out_en(bank_a_out_en),
    .bank_b_out_en(bank_b_out_en));
`default_nettype wire

// *** verif/dbs_tap_model.sv ***
// dbs_tap_model: test controller driving the scan port
`timescale 1ns/100ps
`default_nettype none
module dbs_tap_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_en
);
    // ------------------------------------------------------------------
    // bit and frame sequencing, test clock idles low
    // ------------------------------------------------------------------
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80;
        tck = 1'h1;
        o = tdo_en ? tdo : 1'bx;
        #80;
        tck = 1'h0;
    endtask : tick
    task automatic walk(input logic [7:0] path, input int n);
        logic o;
        for (int i = 0; i < n; i++) tick(path[i], 1'h0, o);
    endtask : walk
    task automatic tap_reset();
        #37;
        walk(8'h1F, 6);
    endtask : tap_reset
    // capture, exit1, update of the instruction path without shifting
    task automatic ir_short();
        #37;
        walk(8'h1B, 6);
    endtask : ir_short
    task automatic scan(input logic ir, input int n, input logic [41:0] din,
                        output logic [41:0] dout);
        logic o;
        dout = '0;
        #37;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : dbs_tap_model
`default_nettype wire

// *** verif/tb_dual_byte_register_boundary_scan.sv ***
// tb_dual_byte_register_boundary_scan: self-checking bench for dbs_top
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb_dual_byte_register_boundary_scan;
    // arbitrary identity word
    localparam logic [31:0] ID_WORD = {4'h3, 6'h12, 10'h155, 11'h2AB, 1'h1};
    localparam logic [7:0] CODES [10] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h41,
                                          8'h42, 8'h22, 8'hAA, 8'hFF, 8'h55};
    localparam logic [1:0] KIND [10] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h0,
                                         2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [8:0] a_in = 9'h000;
    logic [8:0] b_in = 9'h000;
    logic a_clk = 1'h0;
    logic b_clk = 1'h0;
    logic a_pin_n = 1'h0;
    logic b_pin_n = 1'h0;
    logic tck, tms, tdi, tdo, tdo_en, a_en, b_en, look = 1'h0;
    logic [8:0] a_out, b_out, st_a = 9'h000, st_b = 9'h000;
    logic [1:0] sel = 2'h0;
    logic [31:0] lfsr_q = 32'hE99DEE85;
    logic [41:0] res, cells, e, act;
    logic [41:0] exp_q[$];
    string nm_q[$];
    string n;
    int errors = 0;
    int samples_checked = 0;
    always #5 clock = ~clock;
    dbs_top #(.ID_VERSION(ID_WORD[31:28]), .ID_ENTITY(ID_WORD[27:22]),
        .ID_PART(ID_WORD[21:12]), .ID_MAKER(ID_WORD[11:1])) dut_u (
        .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_en(tdo_en), .bank_a_data_in(a_in), .bank_b_data_in(b_in),
        .bank_a_clock(a_clk), .bank_b_clock(b_clk), .bank_a_enable_pin_n(a_pin_n),
        .bank_b_enable_pin_n(b_pin_n), .bank_a_data_out(a_out), .bank_a_out_en(a_en),
        .bank_b_data_out(b_out), .bank_b_out_en(b_en));
    dbs_tap_model tap_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_en(tdo_en));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [8:0] rev9(input logic [8:0] v);
        for (int i = 0; i < 9; i++) rev9[i] = v[8 - i];
    endfunction : rev9
    function automatic logic [41:0] view(input logic en, input logic [8:0] d);
        return {32'h0, en, en ? d : 9'h000};
    endfunction : view
    task automatic wait_c(input int k);
        repeat (k) @(posedge clock);
    endtask : wait_c
    task automatic test_done();
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic note(input string nm, input logic [41:0] x, input logic [1:0] s);
        exp_q.push_back(x);
        nm_q.push_back(nm);
        sel <= s;
        look <= 1'h1;
        wait_c(1);
        look <= 1'h0;
        wait_c(1);
    endtask : note
    task automatic banks(input logic ea, input logic eb);
        note("bank_a", view(ea, st_a), 2'h0);
        note("bank_b", view(eb, st_b), 2'h1);
    endtask : banks
    task automatic store(input logic ca, input logic cb);
        lfsr_q = lfsr(lfsr_q);
        a_in <= lfsr_q[8:0];
        b_in <= lfsr_q[24:16];
        wait_c(4);
        a_clk <= ca;
        b_clk <= cb;
        wait_c(4);
        a_clk <= 1'h0;
        b_clk <= 1'h0;
        wait_c(6);
        if (ca) st_a = lfsr_q[8:0];
        if (cb) st_b = lfsr_q[24:16];
    endtask : store
    task automatic pins(input logic pa, input logic pb);
        a_pin_n <= pa;
        b_pin_n <= pb;
        wait_c(8);
    endtask : pins
    task automatic shift(input logic ir, input int k, input logic [41:0] din);
        tap_u.scan(ir, k, din, res);
        wait_c(12);
    endtask : shift
    // ------------------------------------------------------------------
    // result monitor and run
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (look) begin
            e = exp_q.pop_front();
            n = nm_q.pop_front();
            act = sel == 2'h0 ? view(a_en, a_out) : sel == 2'h1 ? view(b_en, b_out) : res;
            `CHK(n, e, act)
        end
    end
    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        wait_c(2);
        store(1'h1, 1'h1);
        banks(1'h0, 1'h0);
        pins(1'h1, 1'h0);
        pins(1'h0, 1'h0);
        banks(1'h1, 1'h0);
        pins(1'h0, 1'h1);
        pins(1'h0, 1'h0);
        banks(1'h1, 1'h1);
        store(1'h1, 1'h0);
        banks(1'h1, 1'h1);
        pins(1'h1, 1'h0);
        banks(1'h0, 1'h1);
        store(1'h0, 1'h0);
        pins(1'h0, 1'h0);
        banks(1'h1, 1'h1);
        tap_u.tap_reset();
        shift(1'h0, 32, 42'h0);
        note("ident", {10'h0, ID_WORD}, 2'h2);
        lfsr_q = lfsr(lfsr_q);
        a_in <= lfsr_q[8:0];
        b_in <= lfsr_q[20:12];
        cells = {lfsr_q[9:0], lfsr_q};
        wait_c(4);
        tap_u.ir_short();
        shift(1'h0, 42, cells);
        note("capture", {6'h09, rev9(a_in), rev9(b_in), rev9(st_a), rev9(st_b)},
             2'h2);
        for (int i = 0; i < 10; i++) begin
            shift(1'h1, 8, {34'h0, CODES[i]});
            note("ir_capture", 42'h81, 2'h2);
            if (KIND[i] == 2'h1) begin
                note("drive_a", view(cells[39], rev9(cells[17:9])), 2'h0);
                note("drive_b", view(cells[36], rev9(cells[8:0])), 2'h1);
            end else begin
                banks(KIND[i] == 2'h0, KIND[i] == 2'h0);
            end
        end
        lfsr_q = lfsr(lfsr_q);
        shift(1'h0, 9, {33'h0, lfsr_q[8:0]});
        note("bypass", {33'h0, lfsr_q[7:0], 1'h0}, 2'h2);
        test_done();
    end
endmodule : tb_dual_byte_register_boundary_scan
`default_nettype wire
